// *** capture_timer_16bit.sv ***
// Contract
// RL1: In interval mode an interrupt is raised each time the count reaches the first compare value.
// RL2: The timer output can toggle on each compare match, giving a square wave set by the compare.
// RL3: In event mode the count steps once for each valid edge on input pin A.
// RL4: One-shot mode drives a single pulse that starts and ends at the two compare values.
// RL5: PPG mode repeats a wave whose period and high width are set by the two compare values.
// RL6: Pulse durations are measured by capturing the count on input pin edges.
// RL7: Cascade mode chains an 8-bit counter clocked by pin A events ahead of the 16-bit count.
// RL8: In cascade mode pin A events are only accepted while the gate input is high.
// RL9: With reverse phase set, the first capture takes pin A on the edge opposite the valid edge.
// RL10: A reverse-phase capture into the first register raises no first interrupt.
// RL11: With reverse phase clear, the first capture takes pin B edges per the secondary field.
// RL12: The second capture takes pin A edges per the primary field, both edges included.
// RL13: Second captures do not depend on the reverse-phase bit.
// RL14: With reverse phase set, a pin B edge captures nothing but still raises the first interrupt.
// RL15: Clear-and-start mode clears on the valid pin A edge and captures on the opposite edge.
// RL16: The output can be set to invert each time the count is captured and cleared.
// RL17: Reset clears count, captures and selections, and the count stays stopped until enabled.
`timescale 1ns/100ps

module capture_timer_16bit #(
    parameter int DATA_W = 16,
    parameter int EXT_W  = 8
) (
    input  wire logic                               CLOCK,
    input  wire logic                               RST_N,
    input  wire logic [capture_timer_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0]                  WDATA,
    input  wire logic                               WR,
    input  wire logic                               RD,
    output logic      [DATA_W-1:0]                  RDATA,
    input  wire logic                               INPUT_PIN_A,
    input  wire logic                               INPUT_PIN_B,
    input  wire logic                               EVENT_GATE,
    output logic                                    TIMER_OUTPUT_PIN,
    output logic                                    IRQ_CAPTURE_FIRST,
    output logic                                    IRQ_CAPTURE_SECOND,
    output logic                                    IRQ
);

    // **********
    // Types and helpers
    // **********
    typedef enum logic {OS_IDLE, OS_RUN} one_shot_e;

    localparam int DIV_W = 8;

    function automatic logic div_tick(input logic [DIV_W-1:0] cnt,
                                      input logic [capture_timer_pkg::DIV_SEL_W-1:0] sel);
        logic [DIV_W-1:0] mask;
        mask = DIV_W'((9'h001 << sel) - 9'h001);
        return (cnt & mask) == '0;
    endfunction

    function automatic logic is_addr(input logic [capture_timer_pkg::ADDR_W-1:0] a,
                                     input logic [capture_timer_pkg::ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // **********
    // Registers
    // **********
    logic [capture_timer_pkg::MODE_W-1:0]     mode_q;
    logic [6:0]                               prescale_q;
    logic [2:0]                               capctl_q;
    logic [capture_timer_pkg::OUT_CTL_W-1:0]  outctl_q;
    logic [DATA_W-1:0]                        first_q;
    logic [DATA_W-1:0]                        first_d;
    logic [DATA_W-1:0]                        second_q;
    logic [DATA_W-1:0]                        second_d;
    logic [DATA_W-1:0]                        count_q;
    logic [DATA_W-1:0]                        count_d;
    logic [EXT_W-1:0]                         ext_q;
    logic [EXT_W-1:0]                         ext_d;
    logic [capture_timer_pkg::IRQ_W-1:0]      status_q;
    logic [capture_timer_pkg::IRQ_W-1:0]      status_d;
    logic [capture_timer_pkg::IRQ_W-1:0]      mask_q;
    logic [DIV_W-1:0]                         div_q;
    logic                                     out_q;
    logic                                     out_d;
    one_shot_e                                os_q;
    one_shot_e                                os_d;
    logic [DATA_W-1:0]                        rdata_q;
    logic                                     irq_q;
    logic                                     irq_first_q;
    logic                                     irq_second_q;

    // **********
    // Register port decode
    // **********
    wire wr_mode   = WR && is_addr(ADDR, capture_timer_pkg::OFS_TIMER_MODE_CONTROL);
    wire wr_pre    = WR && is_addr(ADDR, capture_timer_pkg::OFS_PRESCALER_MODE);
    wire wr_capctl = WR && is_addr(ADDR, capture_timer_pkg::OFS_CAPTURE_CONTROL);
    wire wr_outctl = WR && is_addr(ADDR, capture_timer_pkg::OFS_OUTPUT_CONTROL);
    wire wr_first  = WR && is_addr(ADDR, capture_timer_pkg::OFS_CAPTURE_REG_FIRST);
    wire wr_second = WR && is_addr(ADDR, capture_timer_pkg::OFS_CAPTURE_REG_SECOND);
    wire wr_status = WR && is_addr(ADDR, capture_timer_pkg::OFS_IRQ_STATUS);
    wire wr_mask   = WR && is_addr(ADDR, capture_timer_pkg::OFS_IRQ_MASK);

    wire out_load    = wr_outctl && WDATA[capture_timer_pkg::OUT_LOAD_BIT];
    wire out_trigger = wr_outctl && WDATA[capture_timer_pkg::OUT_TRIGGER_BIT];

    // **********
    // Field decode
    // **********
    wire [1:0] primary_edge_sel   = prescale_q[capture_timer_pkg::PRIMARY_EDGE_LSB +: 2];
    wire [1:0] secondary_edge_sel = prescale_q[capture_timer_pkg::SECONDARY_EDGE_LSB +: 2];
    wire [capture_timer_pkg::DIV_SEL_W-1:0] div_sel =
        prescale_q[capture_timer_pkg::DIV_SEL_LSB +: capture_timer_pkg::DIV_SEL_W];

    wire cap_first_mode       = capctl_q[capture_timer_pkg::CAP_FIRST_BIT];
    wire reverse_phase_select = capctl_q[capture_timer_pkg::REVERSE_PHASE_BIT];
    wire cap_second_mode      = capctl_q[capture_timer_pkg::CAP_SECOND_BIT];

    wire out_enable     = outctl_q[capture_timer_pkg::OUT_ENABLE_BIT];
    wire out_inv_first  = outctl_q[capture_timer_pkg::OUT_INV_FIRST_BIT];
    wire out_inv_second = outctl_q[capture_timer_pkg::OUT_INV_SECOND_BIT];
    wire out_inv_clear  = outctl_q[capture_timer_pkg::OUT_INV_CLEAR_BIT];

    wire m_interval = mode_q == capture_timer_pkg::MODE_INTERVAL;
    wire m_clear    = mode_q == capture_timer_pkg::MODE_CLEAR_START;
    wire m_event    = mode_q == capture_timer_pkg::MODE_EVENT;
    wire m_one_shot = mode_q == capture_timer_pkg::MODE_ONE_SHOT;
    wire m_ppg      = mode_q == capture_timer_pkg::MODE_PPG;
    wire m_cascade  = mode_q == capture_timer_pkg::MODE_CASCADE;

    // **********
    // Pin edges
    // **********
    capture_timer_pkg::edge_s a_evt;
    capture_timer_pkg::edge_s a_any;
    capture_timer_pkg::edge_s b_evt;

    edge_detect u_edge_a (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .pin   (INPUT_PIN_A),
        .sel   (primary_edge_sel),
        .evt   (a_evt)
    );

    edge_detect u_edge_b (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .pin   (INPUT_PIN_B),
        .sel   (secondary_edge_sel),
        .evt   (b_evt)
    );

    assign a_any = a_evt;

    // The edge opposite the valid one; code 11 has no opposite and never captures.
    wire a_reverse = (primary_edge_sel == capture_timer_pkg::EDGE_RISING  && a_any.fall) ||
                     (primary_edge_sel == capture_timer_pkg::EDGE_FALLING && a_any.rise); // RL9

    // **********
    // Count enable and compare
    // **********
    wire pre_tick = div_tick(div_q, div_sel);
    wire ext_step = m_cascade && EVENT_GATE && a_evt.valid; // RL8
    wire ext_wrap = ext_step && (ext_q == {EXT_W{1'b1}});

    wire count_en = ((m_interval || m_clear || m_ppg) && pre_tick) ||
                    (m_event && a_evt.valid) || // RL3
                    (m_one_shot && os_q == OS_RUN && pre_tick) ||
                    ext_wrap; // RL7

    wire match_first  = !cap_first_mode && count_q == first_q;
    wire match_second = !cap_second_mode && count_q == second_q;
    wire hit_first    = count_en && match_first;
    wire hit_second   = count_en && match_second;
    wire overflow     = count_en && count_q == {DATA_W{1'b1}};

    // Clear-and-start takes the valid pin A edge as its clear.
    wire pin_clear   = m_clear && a_evt.valid; // RL15
    wire wrap_clear  = hit_first && (m_interval || m_event || m_ppg || m_one_shot); // RL1
    wire os_start    = m_one_shot && out_trigger && os_q == OS_IDLE;

    always_comb begin
        count_d = count_q;
        if (pin_clear || os_start) begin
            count_d = '0;
        end else if (wrap_clear) begin
            count_d = '0;
        end else if (count_en) begin
            count_d = count_q + 1'b1;
        end
    end

    always_comb begin
        ext_d = ext_q;
        if (!m_cascade) begin
            ext_d = '0;
        end else if (ext_step) begin
            ext_d = ext_q + 1'b1; // RL7
        end
    end

    always_comb begin
        os_d = os_q;
        case (os_q)
            OS_IDLE: begin
                if (os_start) begin
                    os_d = OS_RUN;
                end
            end
            OS_RUN: begin
                if (!m_one_shot || hit_first) begin
                    os_d = OS_IDLE; // RL4
                end
            end
            default: begin
                os_d = OS_IDLE;
            end
        endcase
    end

    // **********
    // Captures
    // **********
    // Pin B keeps its interrupt in both phases; only the capture source moves.
    wire cap_first_take  = cap_first_mode &&
                           (reverse_phase_select ? a_reverse : b_evt.valid); // RL9 RL11 RL15
    wire cap_first_irq   = cap_first_mode && b_evt.valid; // RL10 RL11 RL14
    wire cap_second_take = cap_second_mode && a_evt.valid; // RL12 RL13

    always_comb begin
        first_d = first_q;
        if (cap_first_take) begin
            first_d = count_q; // RL6
        end else if (wr_first && !cap_first_mode) begin
            first_d = WDATA;
        end
    end

    always_comb begin
        second_d = second_q;
        if (cap_second_take) begin
            second_d = count_q; // RL6
        end else if (wr_second && !cap_second_mode) begin
            second_d = WDATA;
        end
    end

    // **********
    // Timer output
    // **********
    always_comb begin
        out_d = out_q;
        if (!out_enable) begin
            out_d = 1'b0;
        end else if (out_load) begin
            out_d = WDATA[capture_timer_pkg::OUT_LEVEL_BIT];
        end else if (m_ppg) begin
            if (wrap_clear) begin
                out_d = 1'b1; // RL5
            end else if (hit_second) begin
                out_d = 1'b0; // RL5
            end
        end else if (m_one_shot) begin
            if (hit_second) begin
                out_d = 1'b1; // RL4
            end else if (hit_first) begin
                out_d = 1'b0; // RL4
            end
        end else if (pin_clear && out_inv_clear) begin
            out_d = ~out_q; // RL16
        end else if ((hit_first && out_inv_first) ^ (hit_second && out_inv_second)) begin
            out_d = ~out_q; // RL2
        end
    end

    // **********
    // Interrupt status
    // **********
    logic [capture_timer_pkg::IRQ_W-1:0] events;

    assign events[capture_timer_pkg::IRQ_FIRST_BIT]  = hit_first || cap_first_irq; // RL1 RL14
    assign events[capture_timer_pkg::IRQ_SECOND_BIT] = hit_second || cap_second_take; // RL12
    assign events[capture_timer_pkg::IRQ_OVF_BIT]    = overflow;

    // A new event in the clearing cycle survives the clear.
    assign status_d = (status_q & ~(wr_status ? WDATA[capture_timer_pkg::IRQ_W-1:0] : '0)) |
                      events;

    // **********
    // Read mux
    // **********
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (ADDR)
            capture_timer_pkg::OFS_TIMER_MODE_CONTROL: rd_mux = DATA_W'(mode_q);
            capture_timer_pkg::OFS_PRESCALER_MODE:     rd_mux = DATA_W'(prescale_q);
            capture_timer_pkg::OFS_CAPTURE_CONTROL:    rd_mux = DATA_W'(capctl_q);
            capture_timer_pkg::OFS_OUTPUT_CONTROL:     rd_mux = DATA_W'(outctl_q);
            capture_timer_pkg::OFS_CAPTURE_REG_FIRST:  rd_mux = first_q;
            capture_timer_pkg::OFS_CAPTURE_REG_SECOND: rd_mux = second_q;
            capture_timer_pkg::OFS_MAIN_COUNT:         rd_mux = count_q;
            capture_timer_pkg::OFS_EXT_COUNT:          rd_mux = DATA_W'(ext_q);
            capture_timer_pkg::OFS_IRQ_STATUS:         rd_mux = DATA_W'(status_q);
            capture_timer_pkg::OFS_IRQ_MASK:           rd_mux = DATA_W'(mask_q);
            default:                                   rd_mux = '0;
        endcase
    end

    // **********
    // Configuration flops
    // **********
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q     <= capture_timer_pkg::MODE_STOP; // RL17
            prescale_q <= '0;
            capctl_q   <= '0;
            outctl_q   <= '0;
            mask_q     <= '0;
        end else begin
            if (wr_mode) mode_q <= WDATA[capture_timer_pkg::MODE_LSB +: capture_timer_pkg::MODE_W];
            if (wr_pre) prescale_q <= WDATA[6:0];
            if (wr_capctl) capctl_q <= WDATA[2:0];
            if (wr_outctl) outctl_q <= WDATA[capture_timer_pkg::OUT_CTL_W-1:0];
            if (wr_mask) mask_q <= WDATA[capture_timer_pkg::IRQ_W-1:0];
        end
    end

    // **********
    // Counting flops
    // **********
    // The divider runs only while a mode is active, so a restart has a known phase.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            div_q    <= '0;
            count_q  <= '0; // RL17
            ext_q    <= '0;
            first_q  <= '0;
            second_q <= '0;
            os_q     <= OS_IDLE;
            out_q    <= 1'b0;
            status_q <= '0;
        end else begin
            div_q    <= (mode_q == capture_timer_pkg::MODE_STOP) ? '0 : div_q + 1'b1;
            count_q  <= count_d;
            ext_q    <= ext_d;
            first_q  <= first_d;
            second_q <= second_d;
            os_q     <= os_d;
            out_q    <= out_d;
            status_q <= status_d;
        end
    end

    // **********
    // Output flops
    // **********
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q      <= '0;
            irq_q        <= 1'b0;
            irq_first_q  <= 1'b0;
            irq_second_q <= 1'b0;
        end else begin
            rdata_q      <= RD ? rd_mux : '0;
            irq_q        <= |(status_d & mask_q);
            irq_first_q  <= events[capture_timer_pkg::IRQ_FIRST_BIT];
            irq_second_q <= events[capture_timer_pkg::IRQ_SECOND_BIT];
        end
    end

    assign RDATA              = rdata_q;
    assign TIMER_OUTPUT_PIN   = out_q;
    assign IRQ                = irq_q;
    assign IRQ_CAPTURE_FIRST  = irq_first_q;
    assign IRQ_CAPTURE_SECOND = irq_second_q;

endmodule // capture_timer_16bit

// *** capture_timer_pkg.sv ***
package capture_timer_pkg;

    // ****************************************************************
    // Register map, word index on the plain register port
    // ****************************************************************
    localparam int ADDR_W = 4;

    localparam logic [3:0] OFS_TIMER_MODE_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PRESCALER_MODE     = 4'h1;
    localparam logic [3:0] OFS_CAPTURE_CONTROL    = 4'h2;
    localparam logic [3:0] OFS_OUTPUT_CONTROL     = 4'h3;
    localparam logic [3:0] OFS_CAPTURE_REG_FIRST  = 4'h4;
    localparam logic [3:0] OFS_CAPTURE_REG_SECOND = 4'h5;
    localparam logic [3:0] OFS_MAIN_COUNT         = 4'h6;
    localparam logic [3:0] OFS_EXT_COUNT          = 4'h7;
    localparam logic [3:0] OFS_IRQ_STATUS         = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK           = 4'h9;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MODE_LSB = 0;
    localparam int MODE_W   = 3;

    localparam int PRIMARY_EDGE_LSB   = 0;
    localparam int SECONDARY_EDGE_LSB = 2;
    localparam int DIV_SEL_LSB        = 4;
    localparam int DIV_SEL_W          = 3;

    localparam int CAP_FIRST_BIT      = 0;
    localparam int REVERSE_PHASE_BIT  = 1;
    localparam int CAP_SECOND_BIT     = 2;

    localparam int OUT_ENABLE_BIT     = 0;
    localparam int OUT_INV_FIRST_BIT  = 1;
    localparam int OUT_INV_SECOND_BIT = 2;
    localparam int OUT_INV_CLEAR_BIT  = 3;
    localparam int OUT_LEVEL_BIT      = 4;
    localparam int OUT_LOAD_BIT       = 5;
    localparam int OUT_TRIGGER_BIT    = 6;
    localparam int OUT_CTL_W          = 5;

    localparam int IRQ_FIRST_BIT  = 0;
    localparam int IRQ_SECOND_BIT = 1;
    localparam int IRQ_OVF_BIT    = 2;
    localparam int IRQ_W          = 3;

    // ****************************************************************
    // Operating modes held in the mode field
    // ****************************************************************
    localparam logic [2:0] MODE_STOP        = 3'h0;
    localparam logic [2:0] MODE_INTERVAL    = 3'h1;
    localparam logic [2:0] MODE_CLEAR_START = 3'h2;
    localparam logic [2:0] MODE_EVENT       = 3'h3;
    localparam logic [2:0] MODE_ONE_SHOT    = 3'h4;
    localparam logic [2:0] MODE_PPG         = 3'h5;
    localparam logic [2:0] MODE_CASCADE     = 3'h6;

    // ****************************************************************
    // Edge selection codes
    // ****************************************************************
    localparam logic [1:0] EDGE_FALLING = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    localparam int CLOCK_MHZ = 200;

    typedef struct packed {
        logic rise;
        logic fall;
        logic valid;
    } edge_s;

endpackage

// *** edge_detect.sv ***
`timescale 1ns/100ps

module edge_detect (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         pin,
    input  wire logic [1:0]                   sel,
    output capture_timer_pkg::edge_s          evt
);

    // ****************************************************************
    // Edge detection on a pin already synchronous to the clock
    // ****************************************************************
    logic pin_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin;
        end
    end

    assign rise = pin & ~pin_q;
    assign fall = ~pin & pin_q;

    // Code 10 selects no edge at all.
    assign evt.rise  = rise;
    assign evt.fall  = fall;
    assign evt.valid = (sel == capture_timer_pkg::EDGE_RISING  && rise) ||
                       (sel == capture_timer_pkg::EDGE_FALLING && fall) ||
                       (sel == capture_timer_pkg::EDGE_BOTH    && (rise || fall));

endmodule // edge_detect

// *** capture_timer_16bit_asserts.sv ***
`timescale 1ns/100ps
module capture_timer_16bit_asserts (
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        INPUT_PIN_A,
    input wire logic        INPUT_PIN_B,
    input wire logic        TIMER_OUTPUT_PIN,
    input wire logic        IRQ_CAPTURE_FIRST,
    input wire logic        IRQ_CAPTURE_SECOND,
    input wire logic        IRQ
);
    // **********
    // Shadow of the settings written by software.
    // **********
    logic [2:0] mode_q, cap_q, mask_q;
    logic [6:0] pre_q;
    logic       a_q, b_q, ran_q;
    // Edge codes 01 rise, 00 fall, 11 both, 10 none reduce to one compare.
    wire a_ok = INPUT_PIN_A != a_q && (pre_q[1:0] == 2'h3 || pre_q[1:0] == {1'b0, INPUT_PIN_A});
    wire b_ok = INPUT_PIN_B != b_q && (pre_q[3:2] == 2'h3 || pre_q[3:2] == {1'b0, INPUT_PIN_B});
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            {mode_q, cap_q, mask_q, pre_q, a_q, b_q, ran_q} <= '0;
        end else begin
            a_q   <= INPUT_PIN_A;
            b_q   <= INPUT_PIN_B;
            ran_q <= ran_q | (mode_q != 3'h0);
            if (WR && ADDR == 4'h0) mode_q <= WDATA[2:0];
            if (WR && ADDR == 4'h1) pre_q <= WDATA[6:0];
            if (WR && ADDR == 4'h2) cap_q <= WDATA[2:0];
            if (WR && ADDR == 4'h9) mask_q <= WDATA[2:0];
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    chk_reset_quiet: assert property ($rose(RST_N) |-> !IRQ && !TIMER_OUTPUT_PIN
        && !IRQ_CAPTURE_FIRST && !IRQ_CAPTURE_SECOND) else $error("output after reset");
    chk_stop_read: assert property (!ran_q && mode_q == 3'h0 && RD && ADDR[3:1] == 3'h3
        |=> RDATA == 16'h0000) else $error("count before start");
    chk_cfg_read: assert property (RD && ADDR == 4'h1 |=> RDATA == {9'h000, pre_q})
        else $error("prescale read wrong");
    chk_unmapped_zero: assert property (RD && ADDR > 4'h9 |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    chk_second_cap: assert property (mode_q != 3'h0 && cap_q[2] && a_ok
        |-> ##[1:4] IRQ_CAPTURE_SECOND) else $error("no second capture pulse");
    chk_first_on_b: assert property (mode_q != 3'h0 && cap_q[0] && b_ok
        |-> ##[1:4] IRQ_CAPTURE_FIRST) else $error("no pin B first pulse");
    chk_rev_silent: assert property (IRQ_CAPTURE_FIRST && cap_q[0] |-> $past(b_ok)
        || $past(b_ok, 2) || $past(b_ok, 3) || $past(b_ok, 4)) else $error("first pulse uncaused");
    chk_irq_masked: assert property ((mask_q == 3'h0) [*3] |-> !IRQ)
        else $error("masked interrupt");
    cover property (IRQ_CAPTURE_SECOND);
    cover property (cap_q[1] && a_ok);
    cover property (IRQ);
endmodule // capture_timer_16bit_asserts

bind capture_timer_16bit capture_timer_16bit_asserts u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INPUT_PIN_A(INPUT_PIN_A),
    .INPUT_PIN_B(INPUT_PIN_B), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .IRQ(IRQ),
    .IRQ_CAPTURE_FIRST(IRQ_CAPTURE_FIRST), .IRQ_CAPTURE_SECOND(IRQ_CAPTURE_SECOND));

// *** pulse_source.sv ***
`timescale 1ns/100ps
module pulse_source (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] fire,
    input  wire logic [7:0] width,
    output logic      [1:0] pins
);
    logic [1:0][7:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= '0;
        else for (int i = 0; i < 2; i++) begin
            if (fire[i]) cnt_q[i] <= width;
            else if (cnt_q[i] != 8'h00) cnt_q[i] <= cnt_q[i] - 8'h01;
        end
    end
    assign pins = {cnt_q[1] != 8'h00, cnt_q[0] != 8'h00};
endmodule // pulse_source

// *** capture_timer_16bit_tb_top.sv ***
`timescale 1ns/100ps
module capture_timer_16bit_tb_top;
    logic        CLOCK = 0, RST_N = 0, WR = 0, RD = 0, EVENT_GATE = 0, tout, irq1, irq2, irq;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000, RDATA;
    logic [1:0]  fire = 2'h0, pins;
    logic [7:0]  width = 8'h01;
    int          fail_count = 0, comparisons = 0, n1 = 0, n2 = 0, nt = 0, n, m;
    capture_timer_16bit u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .INPUT_PIN_A(pins[0]), .INPUT_PIN_B(pins[1]),
        .EVENT_GATE(EVENT_GATE), .TIMER_OUTPUT_PIN(tout), .IRQ_CAPTURE_FIRST(irq1),
        .IRQ_CAPTURE_SECOND(irq2), .IRQ(irq));
    pulse_source u_src (.clk(CLOCK), .rst_n(RST_N), .fire(fire), .width(width), .pins(pins));
    initial forever #2.5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        n1 += int'(irq1 === 1'b1);
        n2 += int'(irq2 === 1'b1);
        nt += int'(tout === 1'b1);
    end
    task check(input string s, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask
    task rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge CLOCK);
        {RD, ADDR} <= {1'b1, a};
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 check("rdata", RDATA, e);
    endtask
    task rst();
        RST_N <= 1'b0;
        repeat (20) @(posedge CLOCK);
        RST_N <= 1'b1;
    endtask
    task pulse(input logic [1:0] f, input logic [7:0] w);
        @(posedge CLOCK);
        {fire, width} <= {f, w};
        @(posedge CLOCK);
        fire <= 2'h0;
        repeat (w + 8'h04) @(posedge CLOCK);
    endtask
    // Rise-to-rise spacing of irq1 (s=0) or tout (s=1).
    task automatic gap(input bit s, output int g);
        int t, r = -1;
        logic c, p = 1'b1;
        g = 0;
        for (t = 0; t < 400 && g == 0; t++) begin
            @(posedge CLOCK);
            #1 c = s ? tout : irq1;
            if (c === 1'b1 && p === 1'b0) if (r >= 0) g = t - r; else r = t;
            p = c;
        end
    endtask
    task end_sim();
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge CLOCK);
        fail_count++;
        end_sim();
    end
    initial begin
        rst();
        for (int i = 0; i < 16; i++) rc(i[3:0], 16'h0000);
        wr(4'h9, 16'h0007);
        rc(4'h9, 16'h0007);
        wr(4'h4, 16'h0003);
        wr(4'h3, 16'h0003);
        wr(4'h0, {13'h0, capture_timer_pkg::MODE_INTERVAL});
        gap(0, n);
        check("interval", 16'(n), 16'h0004);
        gap(1, n);
        check("square wave", 16'(n), 16'h0008);
        check("irq", 16'(irq), 16'h0001);
        wr(4'h9, 16'h0000);
        repeat (3) @(posedge CLOCK);
        #1 check("masked irq", 16'(irq), 16'h0000);
        wr(4'h4, 16'h0007);
        wr(4'h5, 16'h0002);
        wr(4'h0, {13'h0, capture_timer_pkg::MODE_PPG});
        gap(1, n);
        check("ppg period", 16'(n), 16'h0008);
        wr(4'h0, 16'h0004);
        wr(4'h3, 16'h0061);
        #1 m = nt;
        repeat (12) @(posedge CLOCK);
        check("one shot", 16'(nt - m), 16'h0005);
        wr(4'h0, 16'h0000);
        wr(4'h8, 16'h0007);
        rc(4'h8, 16'h0000);
        rst();
        wr(4'h1, 16'h0001);
        wr(4'h4, 16'hFFFF);
        wr(4'h0, {13'h0, capture_timer_pkg::MODE_EVENT});
        repeat (5) pulse(2'h1, 8'h02);
        rc(4'h6, 16'h0005);
        rst();
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0007);
        wr(4'h3, 16'h0009);
        wr(4'h0, {13'h0, capture_timer_pkg::MODE_CLEAR_START});
        {n, m} = {n1, n2};
        pulse(2'h1, 8'h05);
        #1 check("timer output", 16'(tout), 16'h0001);
        rc(4'h4, 16'h0004);
        pulse(2'h1, 8'h0C);
        rc(4'h4, 16'h000B);
        check("first pulses", 16'(n1 - n), 16'h0000);
        check("second pulses", 16'(n2 - m), 16'h0002);
        pulse(2'h2, 8'h03);
        rc(4'h4, 16'h000B);
        check("pin B pulses", 16'(n1 - n), 16'h0001);
        wr(4'h2, 16'h0005);
        wr(4'h1, 16'h000F);
        {n, m} = {n1, n2};
        pulse(2'h3, 8'h04);
        check("pin B both", 16'(n1 - n), 16'h0002);
        check("pin A both", 16'(n2 - m), 16'h0002);
        rst();
        wr(4'h1, 16'h0001);
        wr(4'h0, {13'h0, capture_timer_pkg::MODE_CASCADE});
        repeat (3) pulse(2'h1, 8'h01);
        rc(4'h7, 16'h0000);
        @(posedge CLOCK) EVENT_GATE <= 1'b1;
        repeat (258) pulse(2'h1, 8'h01);
        rc(4'h7, 16'h0002);
        rc(4'h6, 16'h0001);
        end_sim();
    end
endmodule // capture_timer_16bit_tb_top
